// ==== src/external_data_memory_interface.sv ====
// External data memory interface: turns external moves into pin activity.
// Assumes the core holds the request until done; pins pass through port muxing outside.
//
// Contract
// - Config bit 4 high selects non-multiplexed bus, low multiplexed.
// - Multiplexed mode shares eight pins for low address and data.
// - Latch strobe high while low address shown, then falls for phase two.
// - Phase two: shared pins carry data while read or write strobe asserted.
// - Non-multiplexed mode uses separate address and data pins.
// - Mode 00: all accesses on-chip, addresses wrap on 8k.
// - 8-bit move: high byte from page select, low byte from pointer.
// - 16-bit move: address taken whole from data pointer.
// - Modes 01 and 10: below 8k on-chip, above off-chip.
// - Split without bank select: 8-bit off-chip leaves upper address undriven.
// - 16-bit off-chip move drives the upper address pins throughout; low address pins only when non-multiplexed.
// - Mode 10: 8-bit off-chip drives upper pins from page select.
// - Mode 11: every access off-chip, on-chip RAM invisible.
// - External-only 8-bit move ignores page select, upper pins undriven.
// - Setup, hold, strobe and latch widths programmable in clock periods.
// - Off-chip move lasts programmed times plus four cycles.
// - Multiplexed latch strobe adds at least two cycles.
// - Reset loads setup and hold with maximum delays.
// - Bus pins claimed only while an off-chip move executes.
// - Data drivers off while pins act as inputs, such as reads.
`timescale 1ns/1ps
module external_data_memory_interface
  import xmem_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          interface_config_register,
  input  wire logic [7:0]          page_select_register,
  input  wire logic [7:0]          timing_control_register,
  input  wire logic [7:0]          indirect_pointer_zero,
  input  wire logic [7:0]          indirect_pointer_one,
  input  wire logic [ADDR_W-1:0]   data_pointer,
  input  wire logic                cfg_write,
  input  wire logic                req,
  input  wire logic                req_write,
  input  wire logic                req_wide,
  input  wire logic                req_ptr_sel,
  input  wire logic [DATA_W-1:0]   req_wdata,
  input  wire logic [DATA_W-1:0]   data_in,
  input  wire logic [DATA_W-1:0]   ram_rdata,
  output logic                     done,
  output logic [DATA_W-1:0]        rdata,
  output logic                     ram_en,
  output logic                     ram_we,
  output logic [ONCHIP_ADDR_W-1:0] ram_addr,
  output logic [DATA_W-1:0]        ram_wdata,
  output logic [ADDR_W-1:0]        addr_out,
  output logic                     addr_hi_oe,
  output logic                     addr_lo_oe,
  output logic [DATA_W-1:0]        data_out,
  output logic                     data_oe,
  output logic                     ale,
  output logic                     rd_n,
  output logic                     wr_n,
  output logic                     bus_claim
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed
  {
    state_t                  st;
    logic [7:0]              cfg;
    logic [7:0]              tc;
    logic [CNT_W-1:0]        cnt;
    logic                    mux;
    logic                    wr;
    logic                    hi_drv;
    logic [ADDR_W-1:0]       ea;
    logic [DATA_W-1:0]       wdata;
    logic                    done;
    logic [DATA_W-1:0]       rdata;
    logic                    ram_en;
    logic                    ram_we;
    logic [ONCHIP_ADDR_W-1:0] ram_addr;
    logic [DATA_W-1:0]       ram_wdata;
    logic [ADDR_W-1:0]       addr_out;
    logic                    addr_hi_oe;
    logic                    addr_lo_oe;
    logic [DATA_W-1:0]       data_out;
    logic                    data_oe;
    logic                    ale;
    logic                    rd_n;
    logic                    wr_n;
    logic                    claim;
    logic                    ram_pend;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  localparam regs_t REGS_RESET = '{
    st: ST_IDLE, cfg: CFG_RESET, tc: TC_RESET, cnt: '0, mux: 1'b0, wr: 1'b0,
    hi_drv: 1'b0, ea: '0, wdata: '0, done: 1'b0, rdata: '0, ram_en: 1'b0,
    ram_we: 1'b0, ram_addr: '0, ram_wdata: '0, addr_out: '0, addr_hi_oe: 1'b0,
    addr_lo_oe: 1'b0, data_out: '0, data_oe: 1'b0, ale: 1'b0, rd_n: 1'b1,
    wr_n: 1'b1, claim: 1'b0, ram_pend: 1'b0};

  // ********************************************************************
  // Address formation and routing
  // ********************************************************************
  logic [1:0]        mode;
  logic [ADDR_W-1:0] ea;
  logic              offchip;
  logic [CNT_W-1:0]  setup_cyc;
  logic [CNT_W-1:0]  pulse_cyc;
  logic [CNT_W-1:0]  hold_cyc;
  logic [CNT_W-1:0]  ale_cyc;
  logic              start_xfer;

  always_comb
  begin
    mode = r_q.cfg[CFG_MODE_HI:CFG_MODE_LO];
    if (req_wide)
    begin
      ea = data_pointer;
    end
    else
    begin
      ea = {page_select_register, req_ptr_sel ? indirect_pointer_one : indirect_pointer_zero};
    end
    unique case (mode)
      MODE_INTERNAL: offchip = 1'b0;
      MODE_SPLIT_NB,
      MODE_SPLIT_BS: offchip = (ea[ADDR_W-1:ONCHIP_ADDR_W] != ONCHIP_HI_ZERO);
      MODE_EXTERNAL: offchip = 1'b1;
    endcase
    setup_cyc = CNT_W'(r_q.tc[TC_SETUP_HI:TC_SETUP_LO]);
    pulse_cyc = CNT_W'(r_q.tc[TC_PULSE_HI:TC_PULSE_LO]) + ONE_CYCLE;
    hold_cyc  = CNT_W'(r_q.tc[TC_HOLD_HI:TC_HOLD_LO]);
    ale_cyc   = CNT_W'(r_q.cfg[CFG_ALE_HI:CFG_ALE_LO]) + ONE_CYCLE;
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  always_comb
  begin
    r_d = r_q;
    r_d.done   = 1'b0;
    r_d.ram_en = 1'b0;
    r_d.ram_we = 1'b0;
    start_xfer = 1'b0;
    if (cfg_write && r_q.st == ST_IDLE)
    begin
      r_d.cfg = interface_config_register;
      r_d.tc  = timing_control_register;
    end
    if (r_q.ram_pend)
    begin
      r_d.ram_pend = 1'b0;
      r_d.rdata    = ram_rdata;
      r_d.done     = 1'b1;
    end
    unique case (r_q.st)
      ST_IDLE:
      begin
        if (req && !r_q.done && !r_q.ram_pend && !r_q.ram_en)
        begin
          r_d.wr    = req_write;
          r_d.wdata = req_wdata;
          r_d.ea    = ea;
          if (!offchip)
          begin
            r_d.ram_en    = 1'b1;
            r_d.ram_we    = req_write;
            r_d.ram_addr  = ea[ONCHIP_ADDR_W-1:0];
            r_d.ram_wdata = req_wdata;
            r_d.ram_pend  = !req_write;
            r_d.done      = req_write;
          end
          else
          begin
            r_d.mux    = !r_q.cfg[CFG_MUX_BIT];
            r_d.hi_drv = req_wide || (mode == MODE_SPLIT_BS);
            r_d.st     = ST_FRONT;
            r_d.cnt    = OVERHEAD_FRONT;
            r_d.claim  = 1'b1;
          end
        end
      end
      ST_FRONT:
      begin
        r_d.addr_out   = r_q.ea;
        r_d.addr_hi_oe = r_q.hi_drv;
        r_d.addr_lo_oe = !r_q.mux;
        r_d.cnt        = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          if (r_q.mux)
          begin
            r_d.st       = ST_ALE_HI;
            r_d.cnt      = ale_cyc;
            r_d.ale      = 1'b1;
            r_d.data_out = r_q.ea[DATA_W-1:0];
            r_d.data_oe  = 1'b1;
          end
          else
          begin
            start_xfer = 1'b1;
          end
        end
      end
      ST_ALE_HI:
      begin
        r_d.cnt = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          r_d.ale = 1'b0;
          r_d.st  = ST_ALE_LO;
          r_d.cnt = ale_cyc;
        end
      end
      ST_ALE_LO:
      begin
        r_d.cnt = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          start_xfer = 1'b1;
        end
      end
      ST_SETUP:
      begin
        r_d.data_out = r_q.wdata;
        r_d.data_oe  = r_q.wr;
        r_d.cnt      = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          r_d.st   = ST_PULSE;
          r_d.cnt  = pulse_cyc;
          r_d.rd_n = r_q.wr;
          r_d.wr_n = !r_q.wr;
        end
      end
      ST_PULSE:
      begin
        r_d.cnt = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          r_d.rd_n  = 1'b1;
          r_d.wr_n  = 1'b1;
          if (!r_q.wr)
          begin
            r_d.rdata = data_in;
          end
          // Zero hold spends no cycle
          if (hold_cyc == '0)
          begin
            r_d.st  = ST_BACK;
            r_d.cnt = OVERHEAD_BACK;
          end
          else
          begin
            r_d.st  = ST_HOLD;
            r_d.cnt = hold_cyc;
          end
        end
      end
      ST_HOLD:
      begin
        r_d.cnt = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          r_d.st  = ST_BACK;
          r_d.cnt = OVERHEAD_BACK;
        end
      end
      ST_BACK:
      begin
        r_d.data_oe = 1'b0;
        r_d.cnt     = r_q.cnt - ONE_CYCLE;
        if (r_q.cnt == ONE_CYCLE)
        begin
          r_d.st         = ST_IDLE;
          r_d.addr_hi_oe = 1'b0;
          r_d.addr_lo_oe = 1'b0;
          r_d.claim      = 1'b0;
          r_d.done       = 1'b1;
        end
      end
    endcase
    // Zero setup goes straight to the strobe
    if (start_xfer)
    begin
      r_d.data_out = r_q.wdata;
      r_d.data_oe  = r_q.wr;
      if (setup_cyc == '0)
      begin
        r_d.st   = ST_PULSE;
        r_d.cnt  = pulse_cyc;
        r_d.rd_n = r_q.wr;
        r_d.wr_n = !r_q.wr;
      end
      else
      begin
        r_d.st  = ST_SETUP;
        r_d.cnt = setup_cyc;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= REGS_RESET;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign done       = r_q.done;
  assign rdata      = r_q.rdata;
  assign ram_en     = r_q.ram_en;
  assign ram_we     = r_q.ram_we;
  assign ram_addr   = r_q.ram_addr;
  assign ram_wdata  = r_q.ram_wdata;
  assign addr_out   = r_q.addr_out;
  assign addr_hi_oe = r_q.addr_hi_oe;
  assign addr_lo_oe = r_q.addr_lo_oe;
  assign data_out   = r_q.data_out;
  assign data_oe    = r_q.data_oe;
  assign ale        = r_q.ale;
  assign rd_n       = r_q.rd_n;
  assign wr_n       = r_q.wr_n;
  assign bus_claim  = r_q.claim;

endmodule // external_data_memory_interface

// ==== src/xmem_pkg.sv ====
// Package: constants and types for the external data memory interface.
// Assumes a single system clock domain; configuration arrives as plain ports.
package xmem_pkg;

  localparam int unsigned  ADDR_W          = 16;
  localparam int unsigned  DATA_W          = 8;
  localparam int unsigned  CFG_MUX_BIT     = 4;
  localparam int unsigned  CFG_MODE_HI     = 3;
  localparam int unsigned  CFG_MODE_LO     = 2;
  localparam int unsigned  CFG_ALE_HI      = 1;
  localparam int unsigned  CFG_ALE_LO      = 0;
  localparam int unsigned  ONCHIP_ADDR_W   = 13;
  localparam logic [2:0]   ONCHIP_HI_ZERO  = 3'h0;
  localparam logic [1:0]   MODE_INTERNAL   = 2'h0;
  localparam logic [1:0]   MODE_SPLIT_NB   = 2'h1;
  localparam logic [1:0]   MODE_SPLIT_BS   = 2'h2;
  localparam logic [1:0]   MODE_EXTERNAL   = 2'h3;
  localparam logic [7:0]   CFG_RESET       = 8'h03;
  localparam logic [7:0]   TC_RESET        = 8'hff;
  localparam int unsigned  TC_SETUP_HI     = 7;
  localparam int unsigned  TC_SETUP_LO     = 6;
  localparam int unsigned  TC_PULSE_HI     = 5;
  localparam int unsigned  TC_PULSE_LO     = 2;
  localparam int unsigned  TC_HOLD_HI      = 1;
  localparam int unsigned  TC_HOLD_LO      = 0;
  localparam int unsigned  CNT_W           = 5;
  localparam logic [4:0]   ONE_CYCLE       = 5'h01;
  localparam logic [4:0]   ALE_BASE        = 5'h02;
  localparam logic [4:0]   OVERHEAD_FRONT  = 5'h02;
  localparam logic [4:0]   OVERHEAD_BACK   = 5'h02;

  typedef enum logic [7:0]
  {
    ST_IDLE   = 8'h01,
    ST_FRONT  = 8'h02,
    ST_ALE_HI = 8'h04,
    ST_ALE_LO = 8'h08,
    ST_SETUP  = 8'h10,
    ST_PULSE  = 8'h20,
    ST_HOLD   = 8'h40,
    ST_BACK   = 8'h80
  } state_t;

endpackage : xmem_pkg

// ==== tb/edmi_sram.sv ====
// Partner: external byte SRAM with low-address latch.
// Assumes pin outputs of the interface; drives the data pins it reads.
`timescale 1ns/1ps
module edmi_sram
(
  input  wire logic       clk,
  input  wire logic       mux,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] addr_lo,
  output logic      [7:0] data_in
);
  logic [7:0] mem [256];
  logic [7:0] lat;
  logic [7:0] a;
  assign a = mux ? lat : addr_lo;
  // Released pins show the inverse, not the last value
  assign data_in = data_oe ? data_out : (!rd_n ? mem[a] : ~mem[a]);
  always @(posedge clk)
  begin
    if (ale)
      lat <= data_out;
    if (!wr_n)
      mem[a] <= data_out;
  end
endmodule // edmi_sram

// ==== tb/edmi_sva.sv ====
// Checker: pin-level relations of the external memory interface.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module edmi_sva
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic done,
  input wire logic ram_en,
  input wire logic addr_hi_oe,
  input wire logic addr_lo_oe,
  input wire logic data_oe,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_claim
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_latch;
    ##[1:4] ($fell(ale) && rd_n && wr_n);
  endsequence
  sequence s_strobe;
    ##[1:40] (!rd_n || !wr_n);
  endsequence
  chk_latch_phase:
    assert property ($rose(ale) |-> s_latch ##0 s_strobe) else $error("no strobe after latch");
  chk_one_strobe:
    assert property (!(!rd_n && !wr_n)) else $error("both strobes low");
  chk_pins_claimed:
    assert property ((!rd_n || !wr_n || ale || addr_hi_oe || addr_lo_oe || data_oe) |-> bus_claim)
      else $error("pins driven unclaimed");
  chk_read_release:
    assert property (!rd_n |-> !data_oe) else $error("data driven in read");
  chk_write_data:
    assert property (!wr_n |-> data_oe) else $error("write data not driven");
  chk_ale_shares:
    assert property (ale |-> data_oe && !addr_lo_oe) else $error("bad latch phase pins");
  chk_done_free:
    assert property (done |-> !bus_claim && !data_oe) else $error("pins held at done");
  chk_min_length:
    assert property ($rose(bus_claim) |-> !done[*4] ##[1:600] done) else $error("bad access length");
  chk_onchip_fast:
    assert property (ram_en |-> !bus_claim ##[0:2] done) else $error("slow on-chip access");
endmodule // edmi_sva
bind external_data_memory_interface edmi_sva chk_u (.clk(clk), .rst_n(rst_n), .done(done), .ram_en(ram_en),
  .addr_hi_oe(addr_hi_oe), .addr_lo_oe(addr_lo_oe), .data_oe(data_oe), .ale(ale), .rd_n(rd_n),
  .wr_n(wr_n), .bus_claim(bus_claim));

// ==== tb/test_external_data_memory_interface.sv ====
// Testbench: external moves in all memory and bus modes.
// Assumes the SRAM partner and the bound checker.
`timescale 1ns/1ps
module test_external_data_memory_interface;
  import xmem_pkg::*;
  logic clk = 0, rst_n = 0, cfg_write = 0, req = 0, req_write = 0, req_wide = 0, req_ptr_sel = 0;
  logic [7:0] icr = 0, psr = 0, tcr = 0, ip0 = 0, ip1 = 0, req_wdata = 0, ram_rdata = 8'h3c;
  logic [15:0] data_pointer = 0, addr_out;
  logic [7:0] data_in, rdata, ram_wdata, data_out;
  logic [12:0] ram_addr;
  logic done, ram_en, ram_we, addr_hi_oe, addr_lo_oe, data_oe, ale, rd_n, wr_n, bus_claim;
  logic hi, lo, al, cl, ra, rwe;
  logic [7:0] ahi, alo, dw, rwd;
  logic [12:0] rad;
  int wlen, rlen, clen, alen, mismatches = 0, total_checks = 0;
  always #25 clk = ~clk;
  external_data_memory_interface dut_u (.clk(clk), .rst_n(rst_n), .interface_config_register(icr),
    .page_select_register(psr), .timing_control_register(tcr), .indirect_pointer_zero(ip0),
    .indirect_pointer_one(ip1), .data_pointer(data_pointer), .cfg_write(cfg_write), .req(req),
    .req_write(req_write), .req_wide(req_wide), .req_ptr_sel(req_ptr_sel), .req_wdata(req_wdata),
    .data_in(data_in), .ram_rdata(ram_rdata), .done(done), .rdata(rdata), .ram_en(ram_en),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .addr_out(addr_out),
    .addr_hi_oe(addr_hi_oe), .addr_lo_oe(addr_lo_oe), .data_out(data_out), .data_oe(data_oe),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .bus_claim(bus_claim));
  edmi_sram sram_u (.clk(clk), .mux(!icr[4]), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .data_oe(data_oe),
    .data_out(data_out), .addr_lo(addr_out[7:0]), .data_in(data_in));
  // ************************************************
  // Tasks
  // ************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [7:0] c, input logic [7:0] t);
    @(posedge clk) #1;
    icr = c;
    tcr = t;
    cfg_write = 1;
    @(posedge clk) #1;
    cfg_write = 0;
  endtask
  task automatic mv(input logic w, input logic wide, input logic sel, input logic [7:0] wd);
    @(posedge clk) #1;
    {req, req_write, req_wide, req_ptr_sel, req_wdata} = {1'b1, w, wide, sel, wd};
    {hi, lo, al, cl, ra, rwe, wlen, rlen, clen, alen} = 0;
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk) #1;
      hi |= addr_hi_oe;
      lo |= addr_lo_oe;
      al |= ale;
      cl |= bus_claim;
      ra |= ram_en;
      if (ram_en) {rad, rwe, rwd} = {ram_addr, ram_we, ram_wdata};
      if (addr_hi_oe) ahi = addr_out[15:8];
      if (addr_lo_oe) alo = addr_out[7:0];
      if (!wr_n) dw = data_out;
      wlen += !wr_n;
      rlen += !rd_n;
      clen += bus_claim;
      alen += ale;
      if (done === 1'b1)
        break;
    end
    check(done, 1'b1);
    req = 0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ************************************************
  // Tests
  // ************************************************
  initial
  begin
    #(2000 * 50);
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    check({rd_n, wr_n, bus_claim}, 3'b110);
    $display("test reset done");
    cfg(8'h00, 8'h0c);
    data_pointer = 16'h4005;
    mv(0, 1, 0, 0);
    check({ra, cl, rwe, rad}, {3'b100, 13'h0005});
    check(rdata, 8'h3c);
    mv(1, 1, 0, 8'h77);
    check({ra, cl, rwe, rad}, {3'b101, 13'h0005});
    check(rwd, 8'h77);
    $display("test internal done");
    cfg(8'h14, 8'h0c);
    psr = 8'h40;
    ip1 = 8'h12;
    mv(1, 0, 1, 8'h5a);
    check({cl, hi, lo, al}, 4'b1010);
    check({alo, dw}, 16'h125a);
    check(wlen, 4);
    check(rlen, 0);
    check(clen, 8);
    $display("test split store done");
    cfg(8'h08, 8'h0c);
    mv(0, 0, 1, 0);
    check({cl, hi, lo, al, ahi}, {4'b1101, 8'h40});
    check(rlen, 4);
    check(alen, 1);
    check(clen, 10);
    check(rdata, 8'h5a);
    $display("test bank load done");
    cfg(8'h1c, 8'h0c);
    psr = 8'hff;
    ip0 = 8'h12;
    mv(1, 0, 0, 8'ha5);
    check({cl, hi, lo, ra, dw}, {4'b1010, 8'ha5});
    mv(0, 0, 0, 0);
    check({cl, hi, ra}, 3'b100);
    check(rdata, 8'ha5);
    $display("test external done");
    cfg(8'h14, 8'h0c);
    data_pointer = 16'h1000;
    mv(0, 1, 0, 0);
    check({ra, cl}, 2'b10);
    data_pointer = 16'ha012;
    mv(0, 1, 0, 0);
    check({cl, hi, lo, ahi, alo}, {3'b111, 16'ha012});
    check(rdata, 8'ha5);
    $display("test wide split done");
    summarize();
  end
endmodule // test_external_data_memory_interface
